// ===== verilog/posl_pkg.sv
/*
 holds the constants, format and state types of the position output sync latch.
 assumes a single 100 MHz system clock and a 12-bit binary position source.
*/
package posl_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned POS_W = 12;
  localparam int unsigned BCD_W = 16;
  localparam int unsigned OUT_W = 16;
  // ****************************************************************
  // timing figures in microseconds and derived cycle counts
  // ****************************************************************
  localparam int unsigned FREEZE_DLY_US = 10;
  localparam int unsigned FREEZE_LEN_US = 100;
  localparam int unsigned HOLD_MAX_US = 30000;
  localparam int unsigned HOLD_BOUND_US = 150;
  localparam int unsigned FIXED_HOLD_US = 100;
  localparam int unsigned FREEZE_DLY_CYC = FREEZE_DLY_US * CLK_MHZ;
  localparam int unsigned FREEZE_LEN_CYC = FREEZE_LEN_US * CLK_MHZ;
  localparam int unsigned HOLD_MAX_CYC = HOLD_MAX_US * CLK_MHZ;
  localparam int unsigned FIXED_HOLD_CYC = FIXED_HOLD_US * CLK_MHZ;
  localparam int unsigned CNT_W = 22;
  localparam logic [CNT_W-1:0] CNT_ZERO = 22'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 22'h1;
  typedef enum logic [1:0] {
    FMT_BIN = 2'h0,
    FMT_BCD = 2'h1,
    FMT_GRAY = 2'h2
  } posl_fmt_e;
  typedef enum logic [2:0] {
    ST_LIVE = 3'h1,
    ST_WAIT = 3'h2,
    ST_HOLD = 3'h4
  } posl_state_e;
endpackage : posl_pkg

// ===== verilog/posl_fmt_if.sv
/*
 carries a position word and its chosen output format between the latch and the encoder.
 assumes both ends sit in the clk_sys domain.
*/
`timescale 1ns/1ps
interface posl_fmt_if;
  import posl_pkg::*;
  logic [POS_W-1:0] position;
  posl_fmt_e format;
  logic [OUT_W-1:0] coded;
  modport ctrl (output position, output format, input coded);
  modport enc (input position, input format, output coded);
endinterface : posl_fmt_if

// ===== verilog/posl_encoder.sv
/*
 turns a binary position into binary, bcd or gray output code, registered.
 assumes position below 4096 so four bcd digits suffice.
*/
`timescale 1ns/1ps
module posl_encoder
  import posl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  posl_fmt_if.enc fmt
);
  logic [OUT_W-1:0] coded_q;
  logic [OUT_W-1:0] coded_d;
  logic [BCD_W-1:0] bcd;

  // double dabble binary to bcd
  always_comb begin
    logic [BCD_W+POS_W-1:0] sh;
    sh = '0;
    sh[POS_W-1:0] = fmt.position;
    for (int i = 0; i < POS_W; i++) begin
      for (int d = 0; d < 4; d++) begin
        if (sh[POS_W+4*d +: 4] > 4'h4) begin
          sh[POS_W+4*d +: 4] = sh[POS_W+4*d +: 4] + 4'h3;
        end
      end
      sh = {sh[BCD_W+POS_W-2:0], 1'b0};
    end
    bcd = sh[BCD_W+POS_W-1:POS_W];
  end

  always_comb begin
    case (fmt.format)
      FMT_BCD: coded_d = bcd;
      FMT_GRAY: coded_d = {4'h0, fmt.position ^ (fmt.position >> 1)};
      default: coded_d = {4'h0, fmt.position};
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      coded_q <= '0;
    end else begin
      coded_q <= coded_d;
    end
  end

  assign fmt.coded = coded_q;
endmodule : posl_encoder

// ===== verilog/posl_sync_latch.sv
/*
 position output sync latch: live parallel position word with edge-triggered hold or freeze.
 assumes the transfer input and conversion results are synchronous to clk_sys.
*/
`timescale 1ns/1ps
// Contract
// - handshake mode: after transfer edge wait set delay, then hold the word
// - handshake delay programmable up to 30 ms, or fixed per variant
// - freeze mode: output refreshes every conversion when no freeze active
// - freeze mode: either edge, wait 10 us, freeze 100 us
// - freeze expires by itself, live update resumes without acknowledge
// - gray format changes one bit between adjacent positions
// - word output as bcd, binary or gray, one line per bit
// - transfer input edge sensitive, both edges request transfer
// - handshake: stable word in place within 150 us of each edge; code holds it only after the set delay, up to 30 ms
module posl_sync_latch
  import posl_pkg::*;
#(
  parameter bit FIXED_DELAY = 1'b0,
  parameter int unsigned FIXED_CYC = FIXED_HOLD_CYC,
  parameter int unsigned FREEZE_DLY = FREEZE_DLY_CYC,
  parameter int unsigned FREEZE_LEN = FREEZE_LEN_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [POS_W-1:0] convPos,
  input wire logic convValid,
  input wire logic xferCmd,
  input wire logic delayedHoldSyncMode,
  input wire logic [CNT_W-1:0] holdDelayCyc,
  input wire logic [1:0] outFormat,
  output logic [OUT_W-1:0] posOut,
  output logic holdActive
);
  // ****************************************************************
  // edge detect and timing
  // ****************************************************************
  logic xferPrev_q;
  logic xferEdge;
  posl_state_e state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [POS_W-1:0] livePos_q;
  logic [POS_W-1:0] heldPos_q;
  logic [CNT_W-1:0] progDly;
  logic [CNT_W-1:0] waitCyc;
  posl_fmt_if fmt ();

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      xferPrev_q <= 1'b0;
    end else begin
      xferPrev_q <= xferCmd;
    end
  end
  assign xferEdge = xferCmd ^ xferPrev_q;

  // clamp to 30 ms, least one cycle
  always_comb begin
    progDly = holdDelayCyc;
    if (holdDelayCyc > CNT_W'(HOLD_MAX_CYC)) begin
      progDly = CNT_W'(HOLD_MAX_CYC);
    end
    if (holdDelayCyc == CNT_ZERO) begin
      progDly = CNT_ONE;
    end
  end
  assign waitCyc = delayedHoldSyncMode ? (FIXED_DELAY ? CNT_W'(FIXED_CYC) : progDly)
                                       : CNT_W'(FREEZE_DLY);

  // ****************************************************************
  // mode sequencer
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_LIVE;
      cnt_q <= CNT_ZERO;
    end else begin
      case (state_q)
        ST_LIVE: begin
          if (xferEdge) begin
            state_q <= ST_WAIT;
            cnt_q <= waitCyc - CNT_ONE;
          end
        end
        ST_WAIT: begin
          if (cnt_q == CNT_ZERO) begin
            state_q <= ST_HOLD;
            cnt_q <= CNT_W'(FREEZE_LEN) - CNT_ONE;
          end else begin
            cnt_q <= cnt_q - CNT_ONE;
          end
        end
        ST_HOLD: begin
          if (delayedHoldSyncMode) begin
            if (xferEdge) begin
              state_q <= ST_WAIT;
              cnt_q <= waitCyc - CNT_ONE;
            end
          end else if (cnt_q == CNT_ZERO) begin
            state_q <= ST_LIVE;
          end else begin
            cnt_q <= cnt_q - CNT_ONE;
          end
        end
        default: begin
          state_q <= ST_LIVE;
          cnt_q <= CNT_ZERO;
        end
      endcase
    end
  end

  // ****************************************************************
  // position capture
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      livePos_q <= '0;
    end else if (convValid) begin
      livePos_q <= convPos;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      heldPos_q <= '0;
    end else if (state_q != ST_HOLD) begin
      heldPos_q <= convValid ? convPos : livePos_q;
    end
  end

  assign fmt.position = (state_q == ST_HOLD) ? heldPos_q : livePos_q;
  assign fmt.format = (outFormat == 2'h1) ? FMT_BCD :
                      (outFormat == 2'h2) ? FMT_GRAY : FMT_BIN;

  posl_encoder u_enc (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .fmt(fmt)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      holdActive <= 1'b0;
    end else begin
      holdActive <= (state_q == ST_HOLD);
    end
  end
  assign posOut = fmt.coded;

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_edge_wait: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == ST_LIVE && xferEdge) |=> state_q == ST_WAIT)
    else $error("transfer edge did not start wait");
  chk_freeze_delay: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == ST_LIVE && xferEdge && !delayedHoldSyncMode && $stable(delayedHoldSyncMode))
    |=> (state_q == ST_WAIT && cnt_q == CNT_W'(FREEZE_DLY) - CNT_ONE))
    else $error("freeze delay count wrong");
  chk_hold_stable: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == ST_HOLD && $past(state_q) == ST_HOLD) |-> $stable(heldPos_q))
    else $error("held word changed during hold");
  chk_freeze_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == ST_HOLD && !delayedHoldSyncMode && cnt_q == CNT_ZERO) |=> state_q == ST_LIVE)
    else $error("freeze did not release");
  chk_wait_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == ST_WAIT && cnt_q == CNT_ZERO) |=> state_q == ST_HOLD)
    else $error("wait did not end in hold");
  chk_delay_cap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    delayedHoldSyncMode |-> (waitCyc <= CNT_W'(HOLD_MAX_CYC) && waitCyc != CNT_ZERO))
    else $error("handshake delay out of range");
  chk_live_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == ST_LIVE && convValid) |=> livePos_q == $past(convPos))
    else $error("live word not refreshed");
  chk_hold_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == ST_WAIT && cnt_q == CNT_ZERO) |-> ##2 holdActive)
    else $error("hold flag late");
  cov_freeze: cover property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == ST_HOLD && !delayedHoldSyncMode ##1 state_q == ST_LIVE);
  cov_handshake: cover property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == ST_HOLD && delayedHoldSyncMode && xferEdge);
  cov_gray: cover property (@(posedge clk_sys) disable iff (!rst_n)
    holdActive && outFormat == 2'h2);
endmodule : posl_sync_latch

// ===== verif/posl_reader.sv
/*
 reader model: toggles the transfer command, waits, votes over three samples.
 assumes posOut is settled at the falling edge of clk_sys.
*/
`timescale 1ns/1ps
module posl_reader
  import posl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [OUT_W-1:0] posOut,
  output logic xferCmd
);
  initial xferCmd = 1'b0;
  // ********
  // transfer request and sampling
  // ********
  task automatic kick();
    xferCmd = ~xferCmd;
  endtask : kick
  task automatic transfer(input int dly, output logic [OUT_W-1:0] val);
    logic [OUT_W-1:0] s [3];
    kick();
    repeat (dly) @(negedge clk_sys);
    for (int i = 0; i < 3; i++) begin
      s[i] = posOut;
      @(negedge clk_sys);
    end
    val = (s[0] === s[1] || s[0] === s[2]) ? s[0] : s[1];
  endtask : transfer
  // true when sample a lies within w of sample b, either side
  function automatic bit near(input logic [OUT_W-1:0] a, input logic [OUT_W-1:0] b,
                              input int w);
    return ((a > b) ? int'(a - b) : int'(b - a)) <= w;
  endfunction : near
endmodule : posl_reader

// ===== verif/posl_sync_latch_tb.sv
/*
 testbench of the sync latch: live formats, freeze window and handshake hold.
 assumes the reader model owns the transfer command.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin num_errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module posl_sync_latch_tb;
  import posl_pkg::*;
  localparam int FD = 5;
  localparam int FL = 20;
  localparam int LIMIT = 20000;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [POS_W-1:0] convPos = 12'h0;
  logic convValid = 1'b1;
  logic delayedHoldSyncMode = 1'b0;
  logic [CNT_W-1:0] holdDelayCyc = 22'h0;
  logic [1:0] outFormat = 2'h0;
  logic [OUT_W-1:0] posOut;
  logic holdActive;
  logic xferCmd;
  logic [31:0] seed = 32'hf96a;
  int num_errors = 0;
  int checks = 0;
  int dl [3] = '{0, 10, 200};
  always #5 clk_sys = ~clk_sys;
  posl_sync_latch #(.FREEZE_DLY(FD), .FREEZE_LEN(FL)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .convPos(convPos), .convValid(convValid), .xferCmd(xferCmd),
    .delayedHoldSyncMode(delayedHoldSyncMode), .holdDelayCyc(holdDelayCyc),
    .outFormat(outFormat), .posOut(posOut), .holdActive(holdActive));
  posl_reader rdr (.clk_sys(clk_sys), .posOut(posOut), .xferCmd(xferCmd));
  // ********
  // helpers
  // ********
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [OUT_W-1:0] enc(input logic [POS_W-1:0] p, input logic [1:0] f);
    if (f == FMT_BCD) return {4'(p / 1000), 4'(p / 100 % 10), 4'(p / 10 % 10), 4'(p % 10)};
    if (f == FMT_GRAY) return {4'h0, p ^ (p >> 1)};
    return {4'h0, p};
  endfunction : enc
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  task automatic results();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  initial begin
    #(LIMIT * 10);
    num_errors++;
    results();
  end
  // ********
  // tests
  // ********
  initial begin
    logic [POS_W-1:0] a;
    logic [OUT_W-1:0] v;
    int n;
    cyc(1);
    `CHK("reset word", 16'h0, posOut)
    `CHK("reset hold", 1'b0, holdActive)
    cyc(1);
    rst_n = 1'b1;
    for (int f = 0; f < 4; f++) begin
      for (int k = 0; k < 6; k++) begin
        outFormat = 2'(f);
        convPos = (k == 0) ? 12'hfff : (k == 1) ? 12'h3e7 : 12'(xs());
        cyc(3);
        `CHK("live word", enc(convPos, outFormat), posOut)
      end
    end
    outFormat = FMT_GRAY;
    for (int k = 0; k < 6; k++) begin
      a = 12'(xs());
      convPos = a;
      cyc(3);
      v = posOut;
      convPos = a + 12'h1;
      cyc(3);
      `CHK("gray step", 1'b1, $onehot(v ^ posOut))
    end
    v = posOut;
    convValid = 1'b0;
    convPos = 12'(xs());
    cyc(3);
    `CHK("no new result", v, posOut)
    convValid = 1'b1;
    cyc(3);
    $display("test live done");
    for (int e = 0; e < 2; e++) begin
      outFormat = 2'(xs());
      a = 12'(xs());
      convPos = a;
      cyc(3);
      rdr.kick();
      n = 0;
      while (holdActive !== 1'b1 && n < 50) begin
        cyc(1);
        n++;
      end
      `CHK("freeze delay", 1'b1, n >= FD && n <= FD + 3)
      n = 0;
      while (holdActive === 1'b1 && n < 100) begin
        `CHK("frozen word", enc(a, outFormat), posOut)
        if (n == 3 && e == 0) rdr.kick();
        convPos = 12'(xs());
        cyc(1);
        n++;
      end
      `CHK("freeze length", FL, n)
      cyc(3);
      `CHK("live again", enc(convPos, outFormat), posOut)
    end
    $display("test freeze done");
    delayedHoldSyncMode = 1'b1;
    for (int i = 0; i < 3; i++) begin
      holdDelayCyc = 22'(dl[i]);
      a = 12'(xs());
      convPos = a;
      cyc(3);
      rdr.transfer(dl[i] + 4, v);
      `CHK("held word", enc(a, outFormat), v)
      `CHK("speed window", 1'b1, rdr.near(v, enc(a, outFormat), 0))
      for (int k = 0; k < 30; k++) begin
        convPos = 12'(xs());
        cyc(1);
        `CHK("hold stands", enc(a, outFormat), posOut)
      end
    end
    $display("test handshake done");
    results();
  end
endmodule : posl_sync_latch_tb
